// file: logic/rsv_sequencer.sv
// Purpose: power-up and power-down sequencing, switch and linear rail enables,
//          voltage codes and mode bits for six step-down rails
// Assumes: all inputs synchronous to clk_i, settings inputs come from the I2C side
// Notes: open-drain pins give an enable that is high while the pin is pulled low
// Functional notes
// - Rail and pin enables combine control pin levels with earlier rails' power good.
// - Both control pins falling together run the one power-down sequence, as pin a alone does.
// - Pin a falling first drops output pins a, b; rails then fall 4 ms apart.
// - Load switches a and b follow control pin d; switch c follows pin e.
// - Linear rails b and c follow only I2C settings, no pin or sequence.
// - Shared register set two applies to linear rail a.
// - Shared register set one applies to load switch c.
// - Each rail has a force-PWM bit; clear means automatic PWM/PFM.
// - Rails start at default codes; new codes are accepted any time.
// - Each rail's step range is fixed at build time, not changeable.
// - 10 mV range: zero is 0 V, code 1 is 0.41 V, 10 mV steps.
// - 25 mV range: 0.4 V base; controllers clamp codes 1..24 to 1.000 V.
// - Sleep select pin picks the sleep code for rails with sleep enabled.
// - Last rail defaults to 1.5 V, 1.35 V in sleep, 25 mV, sleep enabled.
// - Output pins c, d follow I2C values, reset low, open drain.
`timescale 1ns/1ps
`include "rsv_map.svh"
module rsv_sequencer
  import rsv_pkg::*;
#(
  parameter int unsigned STAGE_DELAY_CYC =
    `RSV_STAGE_DELAY_MS * 1000000 / `RSV_CLK_PERIOD_NS
)
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // control pins
  input wire logic ctl_pin_a_i,
  input wire logic ctl_pin_b_i,
  input wire logic ctl_pin_d_i,
  input wire logic ctl_pin_e_i,
  input wire logic sleep_select_pin_i,
  // power good from each step-down rail
  input wire rsv_rails_t rail_power_good_i,
  // I2C-side settings
  input wire rsv_rails_t pwm_force_bit_i,
  input wire logic code_wr_i,
  input wire logic [2:0] code_rail_i,
  input wire logic code_sleep_i,
  input wire rsv_code_t code_data_i,
  input wire logic linear_rail_b_on_i,
  input wire logic linear_rail_c_on_i,
  input wire logic shared_two_on_i,
  input wire rsv_code_t shared_two_code_i,
  input wire logic [7:0] shared_one_cfg_i,
  input wire logic output_pin_c_val_i,
  input wire logic output_pin_d_val_i,
  // rail enables and settings
  output rsv_rails_t rail_en_o,
  output rsv_rails_t rail_force_pwm_o,
  output rsv_code_t [`RSV_NUM_RAILS-1:0] rail_code_o,
  output rsv_mv_t [`RSV_NUM_RAILS-1:0] rail_mv_o,
  // load switches and linear rails
  output logic load_switch_a_en_o,
  output logic load_switch_b_en_o,
  output logic load_switch_c_en_o,
  output logic [7:0] load_switch_c_cfg_o,
  output logic linear_rail_a_en_o,
  output rsv_code_t linear_rail_a_code_o,
  output logic linear_rail_b_en_o,
  output logic linear_rail_c_en_o,
  // open-drain output pins
  output logic output_pin_a_o,
  output logic output_pin_a_oe_o,
  output logic output_pin_b_o,
  output logic output_pin_b_oe_o,
  output logic output_pin_c_o,
  output logic output_pin_c_oe_o,
  output logic output_pin_d_o,
  output logic output_pin_d_oe_o
);
  localparam rsv_cnt_t DLY_LAST = `RSV_CNT_W'(STAGE_DELAY_CYC - 1);
  localparam rsv_rails_t RANGE25 = `RSV_RANGE25_MASK;
  localparam rsv_rails_t CTRL = `RSV_CTRL_MASK;
  localparam rsv_rails_t SLEEP_VOLTAGE_ENABLE = `RSV_SLEEP_EN_MASK;

  // voltage-code storage, normal and sleep per rail
  rsv_code_t norm_code_r [`RSV_NUM_RAILS];
  rsv_code_t slp_code_r [`RSV_NUM_RAILS];
  rsv_cnt_t cnt_r [`RSV_NUM_RAILS];
  rsv_rails_t en_r;
  rsv_rails_t pwm_r;
  rsv_code_t code_out_r [`RSV_NUM_RAILS];
  logic out_a_r, out_b_r, out_c_r, out_d_r;
  logic ls_ab_r, ls_c_r, lin_a_r, lin_b_r, lin_c_r;
  logic [7:0] ls_c_cfg_r;
  rsv_code_t lin_a_code_r;

  function automatic rsv_code_t def_code(input int unsigned idx);
    case (idx)
      0: def_code = `RSV_DEF_CODE0;
      1: def_code = `RSV_DEF_CODE1;
      2: def_code = `RSV_DEF_CODE2;
      3: def_code = `RSV_DEF_CODE3;
      4: def_code = `RSV_DEF_CODE4;
      default: def_code = `RSV_DEF_CODE5;
    endcase
  endfunction : def_code

  function automatic rsv_code_t def_sleep(input int unsigned idx);
    def_sleep = (idx == 5) ? `RSV_DEF_SLEEP5 : def_code(idx);
  endfunction : def_sleep

  // stage qualification: first stage needs both control pins, later ones the
  // predecessor enabled and good
  rsv_rails_t qual_w;
  assign qual_w[0] = ctl_pin_a_i && ctl_pin_b_i;
  assign qual_w[`RSV_NUM_RAILS-1:1] = en_r[`RSV_NUM_RAILS-2:0] &
                                      rail_power_good_i[`RSV_NUM_RAILS-2:0];

  // output pins a and b release only with pin a high and their rails good
  wire logic out_a_nxt = ctl_pin_a_i && en_r[2] && rail_power_good_i[2];
  wire logic out_b_nxt = ctl_pin_a_i && en_r[5] && rail_power_good_i[5];

  // stage enables and off-delay counters
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      en_r <= '0;
      for (int n = 0; n < `RSV_NUM_RAILS; n++) begin
        cnt_r[n] <= '0;
      end
    end else if (ce_i) begin
      for (int n = 0; n < `RSV_NUM_RAILS; n++) begin
        if (qual_w[n]) begin
          en_r[n] <= 1'b1;
          cnt_r[n] <= '0;
        end else if (en_r[n]) begin
          if (cnt_r[n] == DLY_LAST) begin
            en_r[n] <= 1'b0;
            cnt_r[n] <= '0;
          end else begin
            cnt_r[n] <= cnt_r[n] + 1'b1;
          end
        end else begin
          cnt_r[n] <= '0;
        end
      end
    end
  end

  // voltage codes, writable whether or not the rail is enabled
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      for (int n = 0; n < `RSV_NUM_RAILS; n++) begin
        norm_code_r[n] <= def_code(n);
        slp_code_r[n] <= def_sleep(n);
      end
    end else if (ce_i && code_wr_i && (code_rail_i < 3'h6)) begin
      if (code_sleep_i) begin
        slp_code_r[code_rail_i] <= code_data_i;
      end else begin
        norm_code_r[code_rail_i] <= code_data_i;
      end
    end
  end

  // active code per rail
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      for (int n = 0; n < `RSV_NUM_RAILS; n++) begin
        code_out_r[n] <= def_code(n);
      end
    end else if (ce_i) begin
      for (int n = 0; n < `RSV_NUM_RAILS; n++) begin
        code_out_r[n] <= (sleep_select_pin_i && SLEEP_VOLTAGE_ENABLE[n]) ?
                         slp_code_r[n] : norm_code_r[n];
      end
    end
  end

  // pins, switches, linear rails and mode bits
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pwm_r <= '0;
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
      out_c_r <= 1'b0;
      out_d_r <= 1'b0;
      ls_ab_r <= 1'b0;
      ls_c_r <= 1'b0;
      ls_c_cfg_r <= 8'h00;
      lin_a_r <= 1'b0;
      lin_a_code_r <= 7'h00;
      lin_b_r <= 1'b0;
      lin_c_r <= 1'b0;
    end else if (ce_i) begin
      pwm_r <= pwm_force_bit_i;
      out_a_r <= out_a_nxt;
      out_b_r <= out_b_nxt;
      out_c_r <= output_pin_c_val_i;
      out_d_r <= output_pin_d_val_i;
      ls_ab_r <= ctl_pin_d_i;
      ls_c_r <= ctl_pin_e_i;
      ls_c_cfg_r <= shared_one_cfg_i;
      lin_a_r <= shared_two_on_i;
      lin_a_code_r <= shared_two_code_i;
      lin_b_r <= linear_rail_b_on_i;
      lin_c_r <= linear_rail_c_on_i;
    end
  end

  // fixed-range decoders, one per rail
  for (genvar g = 0; g < `RSV_NUM_RAILS; g++) begin : g_dec
    assign rail_code_o[g] = code_out_r[g];
    rsv_vid_decode u_dec (
      .code_i(code_out_r[g]),
      .range25_i(RANGE25[g]),
      .ctrl_i(CTRL[g]),
      .mv_o(rail_mv_o[g])
    );
  end

  assign rail_en_o = en_r;
  assign rail_force_pwm_o = pwm_r;
  assign load_switch_a_en_o = ls_ab_r;
  assign load_switch_b_en_o = ls_ab_r;
  assign load_switch_c_en_o = ls_c_r;
  assign load_switch_c_cfg_o = ls_c_cfg_r;
  assign linear_rail_a_en_o = lin_a_r;
  assign linear_rail_a_code_o = lin_a_code_r;
  assign linear_rail_b_en_o = lin_b_r;
  assign linear_rail_c_en_o = lin_c_r;
  // open drain: pin data is always low, enable pulls it down
  assign output_pin_a_o = 1'b0;
  assign output_pin_b_o = 1'b0;
  assign output_pin_c_o = 1'b0;
  assign output_pin_d_o = 1'b0;
  assign output_pin_a_oe_o = !out_a_r;
  assign output_pin_b_oe_o = !out_b_r;
  assign output_pin_c_oe_o = !out_c_r;
  assign output_pin_d_oe_o = !out_d_r;
endmodule : rsv_sequencer

// file: logic/rsv_map.svh
// Purpose: constants of the rail sequencer and voltage-code control
// Assumes: 100 MHz clock
// Notes: codes are 7-bit voltage codes, rail index 0..5 is sequence order
`ifndef RSV_MAP_SVH
`define RSV_MAP_SVH

`define RSV_CLK_PERIOD_NS 10
`define RSV_STAGE_DELAY_MS 4
`define RSV_CNT_W 20
`define RSV_NUM_RAILS 6
`define RSV_CODE_W 7
`define RSV_MV_W 12

// rails with 25 mV steps (bit set) and rails that are external-FET controllers
`define RSV_RANGE25_MASK 6'h3E
`define RSV_CTRL_MASK 6'h07
// rails whose sleep voltage follows the sleep select pin
`define RSV_SLEEP_EN_MASK 6'h20

// factory default normal codes
`define RSV_DEF_CODE0 7'h3C
`define RSV_DEF_CODE1 7'h38
`define RSV_DEF_CODE2 7'h20
`define RSV_DEF_CODE3 7'h54
`define RSV_DEF_CODE4 7'h74
`define RSV_DEF_CODE5 7'h2C
// factory default sleep code of the last rail
`define RSV_DEF_SLEEP5 7'h26

// decode arithmetic, millivolts
`define RSV_BASE_MV 12'h190
`define RSV_STEP10_MV 12'h00A
`define RSV_STEP25_MV 12'h019
`define RSV_CLAMP_MV 12'h3E8
`define RSV_CLAMP_TOP 7'h18

`endif

// file: logic/rsv_pkg.sv
// Purpose: shared types of the rail sequencer
// Assumes: constants come from rsv_map.svh
// Notes: none
`include "rsv_map.svh"
package rsv_pkg;
  typedef logic [`RSV_CODE_W-1:0] rsv_code_t;
  typedef logic [`RSV_MV_W-1:0] rsv_mv_t;
  typedef logic [`RSV_CNT_W-1:0] rsv_cnt_t;
  typedef logic [`RSV_NUM_RAILS-1:0] rsv_rails_t;
endpackage : rsv_pkg

// file: logic/rsv_vid_decode.sv
// Purpose: turn a 7-bit voltage code into a target in millivolts
// Assumes: range and controller flags are fixed factory settings
// Notes: combinational
`timescale 1ns/1ps
`include "rsv_map.svh"
module rsv_vid_decode
  import rsv_pkg::*;
(
  // code in
  input wire rsv_code_t code_i,
  input wire logic range25_i,
  input wire logic ctrl_i,
  // target out
  output rsv_mv_t mv_o
);
  wire rsv_mv_t code_w = rsv_mv_t'(code_i);
  wire rsv_mv_t mv10_w = 12'(`RSV_BASE_MV + code_w * `RSV_STEP10_MV);
  wire rsv_mv_t mv25_w = 12'(`RSV_BASE_MV + code_w * `RSV_STEP25_MV);
  wire logic zero_w = (code_i == 7'h00);
  wire logic clamp_w = ctrl_i && (code_i <= `RSV_CLAMP_TOP);

  assign mv_o = zero_w ? 12'h000 :
                !range25_i ? mv10_w :
                clamp_w ? `RSV_CLAMP_MV : mv25_w;
endmodule : rsv_vid_decode

// file: bench/rsv_pg_model.sv
// Purpose: power good of the six rails as the analog side reports it
// Assumes: slow_i stretches the rise to four cycles
// Notes: power good drops at once when a rail is disabled
`timescale 1ns/1ps
module rsv_pg_model
  import rsv_pkg::*;
(
  // clock and mode
  input wire logic clk_i,
  input wire logic slow_i,
  // rail side
  input wire rsv_rails_t rail_en_i,
  output rsv_rails_t pg_o
);
  rsv_rails_t [3:0] hist_r;
  always_ff @(posedge clk_i) hist_r <= {hist_r[2:0], rail_en_i};
  assign pg_o = rail_en_i & hist_r[0] & (slow_i ? hist_r[1] & hist_r[2] & hist_r[3] : 6'h3F);
endmodule : rsv_pg_model

// file: bench/rsv_seq_monitor.sv
// Purpose: port checks of the rail sequencer
// Assumes: STAGE_DELAY_CYC matches the design
// Notes: rail 0 stands in for the stage timing
`timescale 1ns/1ps
module rsv_seq_monitor
  import rsv_pkg::*;
#(parameter int unsigned STAGE_DELAY_CYC = 20)
(
  // clock and reset
  input wire logic clk_i, nrst_i, ce_i,
  // pins and settings
  input wire logic ctl_pin_a_i, ctl_pin_b_i, ctl_pin_d_i, ctl_pin_e_i,
  input wire logic linear_rail_b_on_i, linear_rail_c_on_i, output_pin_c_val_i,
  input wire rsv_rails_t rail_power_good_i, pwm_force_bit_i,
  // outputs
  input wire rsv_rails_t rail_en_o, rail_force_pwm_o,
  input wire rsv_code_t [5:0] rail_code_o,
  input wire rsv_mv_t [5:0] rail_mv_o,
  input wire logic load_switch_a_en_o, load_switch_b_en_o, load_switch_c_en_o,
  input wire logic linear_rail_b_en_o, linear_rail_c_en_o, output_pin_c_o,
  input wire logic output_pin_a_oe_o, output_pin_b_oe_o, output_pin_c_oe_o
);
  logic [31:0] off_cnt_r, off_cnt_nxt;
  // cycles rail 0 has stayed on since it lost qualification
  assign off_cnt_nxt = !ce_i ? off_cnt_r :
    (rail_en_o[0] && !(ctl_pin_a_i && ctl_pin_b_i)) ? off_cnt_r + 1 : '0;
  always_ff @(posedge clk_i) off_cnt_r <= nrst_i ? off_cnt_nxt : '0;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence pins_dropped;
    ce_i && !ctl_pin_a_i;
  endsequence
  pin_drop_a: assert property (pins_dropped |=> output_pin_a_oe_o && output_pin_b_oe_o)
    else $error("output pins a b not pulled low");
  seq_order_a: assert property (ce_i |=> (rail_en_o[5:1] & ~$past(rail_en_o[5:1])
    & ~$past(rail_en_o[4:0] & rail_power_good_i[4:0])) == 5'h00) else $error("rail out of order");
  first_on_a: assert property (ce_i && ctl_pin_a_i && ctl_pin_b_i |=> rail_en_o[0])
    else $error("rail 0 not enabled");
  off_hold_a: assert property (off_cnt_r > 0 && off_cnt_r < STAGE_DELAY_CYC
    |-> rail_en_o[0]) else $error("rail 0 off too early");
  off_bound_a: assert property (off_cnt_r <= STAGE_DELAY_CYC &&
    (off_cnt_r != STAGE_DELAY_CYC || !rail_en_o[0])) else $error("rail 0 off too late");
  switch_follow_a: assert property (ce_i |=> load_switch_a_en_o == $past(ctl_pin_d_i)
    && load_switch_b_en_o == $past(ctl_pin_d_i) && load_switch_c_en_o == $past(ctl_pin_e_i))
    else $error("load switch mismatch");
  linear_bc_a: assert property (ce_i |=> linear_rail_b_en_o == $past(linear_rail_b_on_i)
    && linear_rail_c_en_o == $past(linear_rail_c_on_i)) else $error("linear rail mismatch");
  force_pwm_a: assert property (ce_i |=> rail_force_pwm_o == $past(pwm_force_bit_i))
    else $error("force pwm mismatch");
  pin_c_a: assert property (ce_i |=> output_pin_c_oe_o == !$past(output_pin_c_val_i)
    && !output_pin_c_o) else $error("output pin c mismatch");
  step10_a: assert property (rail_code_o[0] != 0 |->
    rail_mv_o[0] == 12'(400 + 10 * rail_code_o[0])) else $error("rail 0 decode");
  clamp_a: assert property (rail_code_o[1] inside {[1:24]} |-> rail_mv_o[1] == 12'h3E8)
    else $error("controller clamp");
  step25_a: assert property (rail_code_o[3] != 0 |->
    rail_mv_o[3] == 12'(400 + 25 * rail_code_o[3])) else $error("rail 3 decode");
endmodule : rsv_seq_monitor
bind rsv_sequencer rsv_seq_monitor #(.STAGE_DELAY_CYC(STAGE_DELAY_CYC)) rsv_seq_monitor_inst (.*);

// file: bench/testbench.sv
// Purpose: self-checking bench of the rail sequencer
// Assumes: stage delay shortened to STG cycles
// Notes: inputs change and outputs are read on the falling edge
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
  import rsv_pkg::*;
  localparam int unsigned STG = 20;
  int mismatches = 0, check_count = 0, cyc = 0, gap;
  logic clk_i = 0, nrst_i = 0, ce_i = 1, slow = 0, b;
  logic ctl_pin_a_i = 0, ctl_pin_b_i = 0, ctl_pin_d_i = 0, ctl_pin_e_i = 0;
  logic sleep_select_pin_i = 0, code_wr_i = 0, code_sleep_i = 0, shared_two_on_i = 0;
  logic linear_rail_b_on_i = 0, linear_rail_c_on_i = 0, output_pin_c_val_i = 0;
  logic output_pin_d_val_i = 0, load_switch_a_en_o, load_switch_b_en_o, load_switch_c_en_o;
  logic linear_rail_a_en_o, linear_rail_b_en_o, linear_rail_c_en_o, output_pin_a_o;
  logic output_pin_a_oe_o, output_pin_b_o, output_pin_b_oe_o, output_pin_c_o;
  logic output_pin_c_oe_o, output_pin_d_o, output_pin_d_oe_o;
  logic [2:0] code_rail_i = '0;
  logic [7:0] shared_one_cfg_i = '0, load_switch_c_cfg_o;
  rsv_rails_t pwm_force_bit_i = '0, rail_power_good_i, rail_en_o, rail_force_pwm_o;
  rsv_code_t code_data_i = '0, shared_two_code_i = '0, linear_rail_a_code_o;
  rsv_code_t [5:0] rail_code_o;
  rsv_mv_t [5:0] rail_mv_o;
  rsv_code_t defs [6] = '{7'h3C, 7'h38, 7'h20, 7'h54, 7'h74, 7'h2C};
  int mvs [6] = '{1000, 1800, 1200, 2500, 3300, 1500};
  rsv_sequencer #(.STAGE_DELAY_CYC(STG)) rsv_sequencer_inst (.*);
  rsv_pg_model rsv_pg_model_inst (.clk_i, .slow_i(slow), .rail_en_i(rail_en_o),
    .pg_o(rail_power_good_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  function automatic rsv_mv_t exp_mv(input rsv_code_t c, input int r);
    if (c == 0) return '0;
    if (r == 0) return 12'(400 + 10 * c);
    if (r < 3 && c <= 24) return 12'h3E8;
    return 12'(400 + 25 * c);
  endfunction : exp_mv
  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask : step
  task automatic wr_code(input int r, input rsv_code_t d);
    code_wr_i = 1;
    code_rail_i = 3'(r);
    code_data_i = d;
    step(1);
    code_wr_i = 0;
    step(1);
  endtask : wr_code
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    step(20);
    nrst_i = 1;
    sleep_select_pin_i = 1;
    step(3);
    `CHK(rail_mv_o[5], 12'(1350))
    `CHK(rail_code_o[4], defs[4])
    sleep_select_pin_i = 0;
    step(3);
    for (int i = 0; i < 6; i++) begin
      `CHK(rail_code_o[i], defs[i])
      `CHK(rail_mv_o[i], 12'(mvs[i]))
    end
    `CHK({rail_en_o, output_pin_c_oe_o, output_pin_d_oe_o}, 8'h03)
    `CHK({output_pin_a_o, output_pin_b_o, output_pin_c_o, output_pin_d_o}, 4'h0)
    for (int v = 0; v < 2; v++) begin
      b = v[0];
      ctl_pin_d_i = b;
      ctl_pin_e_i = !b;
      linear_rail_b_on_i = b;
      linear_rail_c_on_i = !b;
      shared_two_on_i = b;
      shared_two_code_i = b ? 7'h55 : 7'h2A;
      shared_one_cfg_i = b ? 8'hA5 : 8'h5A;
      pwm_force_bit_i = b ? 6'h2A : 6'h15;
      output_pin_c_val_i = b;
      output_pin_d_val_i = !b;
      step(1);
      `CHK({load_switch_a_en_o, load_switch_b_en_o, load_switch_c_en_o}, {b, b, !b})
      `CHK({linear_rail_b_en_o, linear_rail_c_en_o}, {b, !b})
      `CHK({linear_rail_a_en_o, linear_rail_a_code_o}, {b, shared_two_code_i})
      `CHK(load_switch_c_cfg_o, shared_one_cfg_i)
      `CHK(rail_force_pwm_o, pwm_force_bit_i)
      `CHK({output_pin_c_oe_o, output_pin_d_oe_o}, {!b, b})
    end
    ce_i = 0;
    ctl_pin_d_i = 0;
    step(2);
    `CHK(load_switch_a_en_o, 1'b1)
    ce_i = 1;
    for (int r = 0; r < 6; r++) begin
      for (int c = 0; c < 128; c++) begin
        wr_code(r, 7'(c));
        `CHK(rail_mv_o[r], exp_mv(7'(c), r))
      end
    end
    wr_code(6, 7'h11);
    `CHK(rail_code_o, {6{7'h7F}})
    code_sleep_i = 1;
    wr_code(5, 7'h30);
    wr_code(4, 7'h31);
    code_sleep_i = 0;
    `CHK(rail_code_o[5:4], {7'h7F, 7'h7F})
    sleep_select_pin_i = 1;
    step(2);
    `CHK(rail_code_o[5:4], {7'h30, 7'h7F})
    sleep_select_pin_i = 0;
    ctl_pin_a_i = 1;
    step(4);
    `CHK(rail_en_o, 6'h00)
    for (int p = 0; p < 2; p++) begin
      slow = !p[0];
      ctl_pin_a_i = 1;
      ctl_pin_b_i = 1;
      for (int k = 0; k < 200 && rail_en_o !== 6'h3F; k++) step(1);
      // last rail's power good and pin b release trail its enable
      step(6);
      `CHK({rail_en_o, output_pin_a_oe_o, output_pin_b_oe_o}, 8'hFC)
      wr_code(2, 7'h30);
      `CHK(rail_mv_o[2], exp_mv(7'h30, 2))
      ctl_pin_a_i = 0;
      ctl_pin_b_i = !p[0];
      step(1);
      `CHK({output_pin_a_oe_o, output_pin_b_oe_o, linear_rail_b_en_o}, 3'b111)
      for (int r = 0; r < 6; r++) begin
        for (gap = 0; rail_en_o[r] === 1'b1 && gap < 100; gap++) step(1);
        `CHK(gap, (r == 0) ? STG - 1 : STG)
      end
      ctl_pin_b_i = 0;
      step(1);
    end
    // reset in mid-run brings back the power-on state
    nrst_i = 0;
    step(1);
    `CHK({rail_en_o, rail_force_pwm_o, load_switch_a_en_o, linear_rail_b_en_o, output_pin_c_oe_o, output_pin_a_oe_o}, 16'h0003)
    `CHK(rail_code_o, {defs[5], defs[4], defs[3], defs[2], defs[1], defs[0]})
    nrst_i = 1;
    step(2);
    wrap_up();
  end
endmodule : testbench
